// [hdl/hsd_cfg.svh]
// Constants for the home-seek deviation-clear block
`ifndef HSD_CFG_SVH
`define HSD_CFG_SVH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define HSD_ADDR_W 8
`define HSD_OFS_CTRL 8'h00
`define HSD_OFS_ASSIGN 8'h04
`define HSD_OFS_CMD 8'h08
`define HSD_OFS_STATUS 8'h0c
`define HSD_OFS_IRQ_STAT 8'h10
`define HSD_OFS_IRQ_EN 8'h14
`define HSD_OFS_IRQ_CLR 8'h18

// ------------------------------------------------------------
// Control register fields
// ------------------------------------------------------------
`define HSD_CTRL_CLR_LSB 0
`define HSD_CTRL_ENC_LSB 2
`define HSD_CTRL_TIM_BIT 4
`define HSD_CTRL_PAT_LSB 8

// ------------------------------------------------------------
// Assignment register fields
// ------------------------------------------------------------
`define HSD_ASG_END_LSB 0
`define HSD_ASG_MOVE_LSB 4
`define HSD_ASG_ABORT_LSB 8
`define HSD_ASG_START_LSB 12

// ------------------------------------------------------------
// Command register bits
// ------------------------------------------------------------
`define HSD_CMD_SEEK_POS 0
`define HSD_CMD_SEEK_NEG 1
`define HSD_CMD_ABORT 2
`define HSD_CMD_DEV_CLR 3

// ------------------------------------------------------------
// Reset values and limits
// ------------------------------------------------------------
`define HSD_CLR_SEL_RST 2'h0
`define HSD_CLR_SEL_MAX 2'h2
`define HSD_ENC_MAX 2'h2
`define HSD_END_RST 3'h2
`define HSD_MOVE_RST 3'h0
`define HSD_ABORT_RST 4'h0
`define HSD_START_RST 4'h0
`define HSD_IN_MAX 3'h5
`define HSD_OUT_MAX 4'h8
`define HSD_PAT_SENSORLESS 4'hc

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define HSD_CLK_NS 50
`define HSD_PULSE_NS 10000
`define HSD_PULSE_CYC ((`HSD_PULSE_NS + `HSD_CLK_NS - 1) / `HSD_CLK_NS)

`endif

// [hdl/hsd_pkg.sv]
// Types shared by the home-seek deviation-clear block
package hsd_pkg;

  // Homing control settings
  typedef struct packed {
    logic [3:0] home_pattern_type;
    logic timing_source_select;
    logic [1:0] encoder_source_select;
    logic [1:0] home_clear_select;
  } hsd_cfg_t;

  // Driver-connector point assignments
  typedef struct packed {
    logic [3:0] homing_start_output_assign;
    logic [3:0] homing_abort_output_assign;
    logic [2:0] moving_input_assign;
    logic [2:0] end_input_assign;
  } hsd_asg_t;

  // Sticky event bits
  typedef struct packed {
    logic panic;
    logic limit;
    logic alarm;
    logic aborted;
    logic done;
  } hsd_evt_t;

  // Homing sequencer states
  typedef enum logic [2:0] {
    HSD_IDLE,
    HSD_SEEK,
    HSD_SL_START,
    HSD_SL_WAIT,
    HSD_ABORT
  } hsd_state_t;

endpackage

// [hdl/hsd_pin_sel.sv]
// Connector point selector: picks one input point and steers one output point
`timescale 1ns/1ps
module hsd_pin_sel import hsd_pkg::*; #(
  parameter int N = 8,
  parameter int SW = 4
) (
  input wire logic [SW-1:0] sel,
  input wire logic [N:1] pins_in,
  input wire logic func_out,
  output logic func_in,
  output logic [N:1] pins_out
);

  // ------------------------------------------------------------
  // Selection, zero meaning unassigned
  // ------------------------------------------------------------
  wire sel_ok = (sel != '0) && (int'(sel) <= N);

  // Input point seen by the function
  assign func_in = sel_ok ? pins_in[int'(sel)] : 1'b0;

  // One-hot steering of the function onto its output point
  genvar g;
  for (g = 1; g <= N; g++) begin : g_out
    assign pins_out[g] = func_out && sel_ok && (int'(sel) == g);
  end

endmodule

// [hdl/hsd_top.sv]
// Home-seek support: timing source, deviation clears, sensor-less handshake
//
// The plain strobed port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "hsd_cfg.svh"

module hsd_top import hsd_pkg::*; #(
  parameter int PULSE_CYC = `HSD_PULSE_CYC,
  parameter int N_IN = 5,
  parameter int N_OUT = 8
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [`HSD_ADDR_W-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic diff_timing_input,
  input wire logic single_timing_input,
  input wire logic ext_index_input,
  input wire logic home_detect,
  input wire logic limit_found,
  input wire logic panic_stop,
  input wire logic [N_IN:1] driver_in,
  output logic [N_OUT:1] driver_out,
  output logic timing_signal,
  output logic seek_run,
  output logic seek_dir_pos,
  output logic own_dev_clear,
  output logic alarm_deviation_clear_out,
  output logic preset_out,
  output logic system_alarm,
  output logic irq
);

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  hsd_cfg_t cfg_q; // Homing settings
  hsd_asg_t asg_q; // Connector assignments
  hsd_evt_t ev_q; // Sticky events
  hsd_evt_t en_q; // Event enables
  hsd_state_t st_q; // Sequencer state
  hsd_state_t st_d; // Next state
  logic [31:0] rdata_q; // Read data, one cycle after strobe
  logic dir_q; // Seek direction
  logic alarm_q; // System alarm level
  logic own_clr_q; // Own counter clear pulse
  logic preset_q; // Preset pulse
  logic [15:0] dcl_cnt_q; // Driver clear pulse timer
  logic [15:0] ab_cnt_q; // Abort output timer
  logic end_prev_q; // Motion-end last sample

  // ------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------
  wire sel_ctrl = (addr == `HSD_OFS_CTRL);
  wire sel_asg = (addr == `HSD_OFS_ASSIGN);
  wire sel_cmd = (addr == `HSD_OFS_CMD);
  wire sel_stat = (addr == `HSD_OFS_STATUS);
  wire sel_ist = (addr == `HSD_OFS_IRQ_STAT);
  wire sel_ien = (addr == `HSD_OFS_IRQ_EN);
  wire sel_icl = (addr == `HSD_OFS_IRQ_CLR);
  wire wr_ctrl = ce && wr && sel_ctrl;
  wire wr_asg = ce && wr && sel_asg;
  wire wr_cmd = ce && wr && sel_cmd;
  wire wr_ien = ce && wr && sel_ien;
  wire wr_icl = ce && wr && sel_icl;

  // ------------------------------------------------------------
  // Write fields
  // ------------------------------------------------------------
  wire [1:0] w_clr = wdata[`HSD_CTRL_CLR_LSB +: 2];
  wire [1:0] w_enc = wdata[`HSD_CTRL_ENC_LSB +: 2];
  wire w_tim = wdata[`HSD_CTRL_TIM_BIT];
  wire [3:0] w_pat = wdata[`HSD_CTRL_PAT_LSB +: 4];
  wire [2:0] w_end = wdata[`HSD_ASG_END_LSB +: 3];
  wire [2:0] w_move = wdata[`HSD_ASG_MOVE_LSB +: 3];
  wire [3:0] w_abort = wdata[`HSD_ASG_ABORT_LSB +: 4];
  wire [3:0] w_start = wdata[`HSD_ASG_START_LSB +: 4];

  // Range checks; a bad field keeps its old value
  wire clr_ok = (w_clr <= `HSD_CLR_SEL_MAX);
  wire enc_ok = (w_enc <= `HSD_ENC_MAX);
  wire end_ok = (w_end <= `HSD_IN_MAX);
  wire move_ok = (w_move <= `HSD_IN_MAX);
  wire abort_ok = (w_abort <= `HSD_OUT_MAX);
  wire start_ok = (w_start <= `HSD_OUT_MAX);

  // Commands
  wire cmd_pos = wr_cmd && wdata[`HSD_CMD_SEEK_POS];
  wire cmd_neg = wr_cmd && wdata[`HSD_CMD_SEEK_NEG];
  wire cmd_seek = cmd_pos || cmd_neg;
  wire cmd_abort = wr_cmd && wdata[`HSD_CMD_ABORT];
  wire cmd_dclr = wr_cmd && wdata[`HSD_CMD_DEV_CLR];

  // ------------------------------------------------------------
  // Timing source selection
  // ------------------------------------------------------------
  wire src_none = !cfg_q.timing_source_select && (cfg_q.encoder_source_select == 2'h0);
  wire tim_mux = cfg_q.timing_source_select ? single_timing_input :
                 (cfg_q.encoder_source_select == 2'h1) ? diff_timing_input :
                 (cfg_q.encoder_source_select == 2'h2) ? ext_index_input : 1'b0;

  // Patterns 1,3,5,7,9,11,13,15 need the timing signal
  wire sensorless = (cfg_q.home_pattern_type == `HSD_PAT_SENSORLESS);
  wire needs_tim = cfg_q.home_pattern_type[0] && !sensorless;
  wire seek_bad = cmd_seek && src_none && needs_tim;

  // ------------------------------------------------------------
  // Driver connector points
  // ------------------------------------------------------------
  logic end_in; // Driver motion-end seen
  logic moving_in; // Driver moving seen
  logic [N_OUT:1] abort_pins; // Abort steered to its point
  logic [N_OUT:1] start_pins; // Start steered to its point
  wire start_func = (st_q == HSD_SL_START);
  wire abort_func = (st_q == HSD_ABORT);

  // Motion-end input point
  hsd_pin_sel #(.N(N_IN), .SW(3)) u_end (
    .sel(asg_q.end_input_assign),
    .pins_in(driver_in),
    .func_out(1'b0),
    .func_in(end_in),
    .pins_out()
  );

  // Moving input point
  hsd_pin_sel #(.N(N_IN), .SW(3)) u_move (
    .sel(asg_q.moving_input_assign),
    .pins_in(driver_in),
    .func_out(1'b0),
    .func_in(moving_in),
    .pins_out()
  );

  // Homing abort output point
  hsd_pin_sel #(.N(N_OUT), .SW(4)) u_abort (
    .sel(asg_q.homing_abort_output_assign),
    .pins_in('0),
    .func_out(abort_func),
    .func_in(),
    .pins_out(abort_pins)
  );

  // Homing start output point
  hsd_pin_sel #(.N(N_OUT), .SW(4)) u_start (
    .sel(asg_q.homing_start_output_assign),
    .pins_in('0),
    .func_out(start_func),
    .func_in(),
    .pins_out(start_pins)
  );

  // ------------------------------------------------------------
  // Event decode
  // ------------------------------------------------------------
  wire in_seek = (st_q == HSD_SEEK);
  wire busy = (st_q != HSD_IDLE);
  wire home_hit = in_seek && home_detect;
  wire limit_hit = in_seek && limit_found;
  wire end_rise = end_in && !end_prev_q;
  wire sl_done = (st_q == HSD_SL_WAIT) && end_rise;
  wire clr_own = (cfg_q.home_clear_select != 2'h2);
  wire clr_drv = (cfg_q.home_clear_select == 2'h1);

  // Own counter clear: home per select, panic unless select 2, software command
  wire own_clr_d = (home_hit && clr_own) || (panic_stop && clr_own) || cmd_dclr;

  // Driver clear pulse start: home with select 1, limit or panic unless select 2
  wire dcl_go = (home_hit && clr_drv) || ((limit_hit || panic_stop) && clr_own);

  // Events raised this cycle
  hsd_evt_t ev_set;
  assign ev_set.done = (home_hit || sl_done) && ce;
  assign ev_set.aborted = busy && (cmd_abort || panic_stop) && ce;
  assign ev_set.alarm = seek_bad;
  assign ev_set.limit = limit_hit && ce;
  assign ev_set.panic = panic_stop && ce;

  // ------------------------------------------------------------
  // Sequencer next state
  // ------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    case (st_q)
      HSD_IDLE: begin
        // Pattern 12 homes through the driver whatever the direction
        if (cmd_seek && !seek_bad) begin
          st_d = sensorless ? HSD_SL_START : HSD_SEEK;
        end
      end
      HSD_SEEK: begin
        // Own seek ends at home, limit, panic or abort command
        if (panic_stop || cmd_abort || home_hit || limit_hit) begin
          st_d = HSD_IDLE;
        end
      end
      HSD_SL_START: begin
        // Start held until the driver leaves its end state or reports moving
        if (panic_stop || cmd_abort) begin
          st_d = HSD_ABORT;
        end else if (!end_in || moving_in) begin
          st_d = HSD_SL_WAIT;
        end
      end
      HSD_SL_WAIT: begin
        // Wait for the driver to report motion end
        if (panic_stop || cmd_abort) begin
          st_d = HSD_ABORT;
        end else if (end_rise) begin
          st_d = HSD_IDLE;
        end
      end
      HSD_ABORT: begin
        // Abort output held for the pulse time
        if (ab_cnt_q == 16'h0001) begin
          st_d = HSD_IDLE;
        end
      end
      default: begin
        st_d = HSD_IDLE;
      end
    endcase
  end

  // ------------------------------------------------------------
  // Settings registers
  // ------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rstn) begin
      cfg_q.home_clear_select <= `HSD_CLR_SEL_RST;
      cfg_q.encoder_source_select <= 2'h0;
      cfg_q.timing_source_select <= 1'b0;
      cfg_q.home_pattern_type <= 4'h0;
    end else if (wr_ctrl) begin
      if (clr_ok) cfg_q.home_clear_select <= w_clr;
      if (enc_ok) cfg_q.encoder_source_select <= w_enc;
      cfg_q.timing_source_select <= w_tim;
      cfg_q.home_pattern_type <= w_pat;
    end
  end

  // Connector assignments, each field checked alone
  always_ff @(posedge clock) begin
    if (!rstn) begin
      asg_q.end_input_assign <= `HSD_END_RST;
      asg_q.moving_input_assign <= `HSD_MOVE_RST;
      asg_q.homing_abort_output_assign <= `HSD_ABORT_RST;
      asg_q.homing_start_output_assign <= `HSD_START_RST;
    end else if (wr_asg) begin
      if (end_ok) asg_q.end_input_assign <= w_end;
      if (move_ok) asg_q.moving_input_assign <= w_move;
      if (abort_ok) asg_q.homing_abort_output_assign <= w_abort;
      if (start_ok) asg_q.homing_start_output_assign <= w_start;
    end
  end

  // ------------------------------------------------------------
  // Interrupt status and enable
  // ------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rstn) begin
      ev_q <= '0;
      en_q <= '0;
    end else if (ce) begin
      // New events win over a clear in the same cycle
      ev_q <= (ev_q & ~(wr_icl ? hsd_evt_t'(wdata[4:0]) : hsd_evt_t'(5'h00))) | ev_set;
      if (wr_ien) en_q <= hsd_evt_t'(wdata[4:0]);
    end
  end

  // ------------------------------------------------------------
  // Sequencer and pulses
  // ------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rstn) begin
      st_q <= HSD_IDLE;
      dir_q <= 1'b1;
      alarm_q <= 1'b0;
      end_prev_q <= 1'b0;
    end else if (ce) begin
      st_q <= st_d;
      end_prev_q <= end_in;
      if (cmd_seek && st_q == HSD_IDLE) dir_q <= cmd_pos;
      // Alarm stands until the next seek command, in any state, that does not lack a needed timing source
      if (seek_bad) begin
        alarm_q <= 1'b1;
      end else if (cmd_seek) begin
        alarm_q <= 1'b0;
      end
    end
  end

  // One-cycle own clear and preset pulses
  always_ff @(posedge clock) begin
    if (!rstn) begin
      own_clr_q <= 1'b0;
      preset_q <= 1'b0;
    end else if (ce) begin
      own_clr_q <= own_clr_d;
      preset_q <= home_hit;
    end
  end

  // Driver clear and abort pulse timers
  always_ff @(posedge clock) begin
    if (!rstn) begin
      dcl_cnt_q <= 16'h0000;
      ab_cnt_q <= 16'h0000;
    end else if (ce) begin
      if (dcl_go) begin
        dcl_cnt_q <= 16'(PULSE_CYC);
      end else if (dcl_cnt_q != 16'h0000) begin
        dcl_cnt_q <= dcl_cnt_q - 16'h0001;
      end
      if (st_q != HSD_ABORT && st_d == HSD_ABORT) begin
        ab_cnt_q <= 16'(PULSE_CYC);
      end else if (ab_cnt_q != 16'h0000) begin
        ab_cnt_q <= ab_cnt_q - 16'h0001;
      end
    end
  end

  // ------------------------------------------------------------
  // Register read
  // ------------------------------------------------------------
  wire [31:0] rd_ctrl = {20'h00000, cfg_q.home_pattern_type, 3'h0,
                         cfg_q.timing_source_select, cfg_q.encoder_source_select,
                         cfg_q.home_clear_select};
  wire [31:0] rd_asg = {16'h0000, asg_q.homing_start_output_assign,
                        asg_q.homing_abort_output_assign, 1'b0,
                        asg_q.moving_input_assign, 1'b0, asg_q.end_input_assign};
  wire [31:0] rd_stat = {24'h000000, alarm_q, moving_in, end_in, tim_mux,
                         dir_q, st_q};
  wire [31:0] rd_mux = sel_ctrl ? rd_ctrl :
                       sel_asg ? rd_asg :
                       sel_stat ? rd_stat :
                       sel_ist ? {27'h0000000, ev_q} :
                       sel_ien ? {27'h0000000, en_q} : 32'h00000000;

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clock) begin
    if (!rstn) begin
      rdata_q <= 32'h00000000;
    end else if (ce) begin
      rdata_q <= rd ? rd_mux : 32'h00000000;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign rdata = rdata_q;
  assign driver_out = abort_pins | start_pins;
  assign timing_signal = tim_mux;
  assign seek_run = in_seek;
  assign seek_dir_pos = dir_q;
  assign own_dev_clear = own_clr_q;
  assign alarm_deviation_clear_out = (dcl_cnt_q != 16'h0000);
  assign preset_out = preset_q;
  assign system_alarm = alarm_q;
  assign irq = |(ev_q & en_q);

endmodule

// [test/hsd_top_chk.sv]
// Concurrent checks on the home-seek block ports
`timescale 1ns/1ps
`include "hsd_cfg.svh"
// ------------------------------------------------------------
// Port checker
// ------------------------------------------------------------
module hsd_top_chk import hsd_pkg::*; #(
  parameter int PULSE_CYC = 4
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [`HSD_ADDR_W-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic diff_timing_input,
  input wire logic single_timing_input,
  input wire logic ext_index_input,
  input wire logic home_detect,
  input wire logic limit_found,
  input wire logic panic_stop,
  input wire logic timing_signal,
  input wire logic seek_run,
  input wire logic own_dev_clear,
  input wire logic alarm_deviation_clear_out,
  input wire logic preset_out,
  input wire logic system_alarm
);
  logic [1:0] clr_q; // Shadow of the clear select
  logic [1:0] enc_q; // Shadow of the encoder select
  logic tim_q; // Shadow of the timing select
  logic [7:0] pcnt_q; // Length of the driver clear pulse
  wire logic ctrl_wr = ce && wr && addr == `HSD_OFS_CTRL; // Control write
  wire logic cmd_wr = ce && wr && addr == `HSD_OFS_CMD; // Command write
  // Expected timing source, single-ended select wins
  wire logic tim_exp = tim_q ? single_timing_input : (enc_q == 2'h1) ? diff_timing_input :
    (enc_q == 2'h2) ? ext_index_input : 1'b0;
  // Shadow registers, out-of-range values are kept out
  always_ff @(posedge clock) begin
    if (!rstn) begin
      clr_q <= `HSD_CLR_SEL_RST;
      enc_q <= 2'h0;
      tim_q <= 1'b0;
      pcnt_q <= 8'h0;
    end else begin
      if (ctrl_wr && wdata[1:0] <= `HSD_CLR_SEL_MAX) clr_q <= wdata[1:0];
      if (ctrl_wr && wdata[3:2] <= `HSD_ENC_MAX) enc_q <= wdata[3:2];
      if (ctrl_wr) tim_q <= wdata[4];
      pcnt_q <= alarm_deviation_clear_out ? pcnt_q + 8'h1 : 8'h0;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  a_timing_route: assert property (timing_signal == tim_exp)
    else $error("timing source mismatch");
  a_home_own_clr: assert property (seek_run && home_detect && clr_q != 2'h2 |=> own_dev_clear)
    else $error("own clear missing at home");
  a_home_drv_clr: assert property (seek_run && home_detect && clr_q == 2'h1 |=>
    alarm_deviation_clear_out) else $error("driver clear missing at home");
  a_sel0_drv_quiet: assert property (seek_run && home_detect && !limit_found && !panic_stop &&
    clr_q == 2'h0 && !alarm_deviation_clear_out |=> !alarm_deviation_clear_out)
    else $error("driver cleared under select zero");
  a_sel2_no_drv: assert property (clr_q == 2'h2 && !alarm_deviation_clear_out |=>
    !alarm_deviation_clear_out) else $error("driver cleared under select two");
  a_sel2_no_own: assert property (clr_q == 2'h2 && !cmd_wr |=> !own_dev_clear)
    else $error("own clear under select two");
  a_pulse_width: assert property ($fell(alarm_deviation_clear_out) |-> int'(pcnt_q) == PULSE_CYC)
    else $error("driver clear pulse width");
  a_limit_drv_clr: assert property (seek_run && limit_found && !home_detect && clr_q != 2'h2 |=>
    alarm_deviation_clear_out) else $error("no driver clear at limit");
  a_preset_cause: assert property (preset_out |-> $past(seek_run) && $past(home_detect))
    else $error("preset without own home");
  a_alarm_cause: assert property ($rose(system_alarm) |-> !seek_run && enc_q == 2'h0 && !tim_q)
    else $error("alarm without missing source");
endmodule

bind hsd_top hsd_top_chk #(.PULSE_CYC(PULSE_CYC)) i_hsd_top_chk (.clock, .rstn, .ce, .addr,
  .wdata, .wr, .diff_timing_input, .single_timing_input, .ext_index_input, .home_detect,
  .limit_found, .panic_stop, .timing_signal, .seek_run, .own_dev_clear,
  .alarm_deviation_clear_out, .preset_out, .system_alarm);

// [test/hsd_drv_model.sv]
// Behavioural push-motion motor driver on the driver connector
`timescale 1ns/1ps
// ------------------------------------------------------------
// Driver model
// ------------------------------------------------------------
module hsd_drv_model (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [8:1] drv_out,
  input wire logic dev_clr,
  input wire logic [3:0] start_pt,
  input wire logic [3:0] stop_pt,
  input wire logic [2:0] end_pt,
  input wire logic [2:0] move_pt,
  input wire logic [7:0] dly,
  output logic [5:1] drv_in
);
  logic busy_q; // Return run in progress
  logic [7:0] cnt_q; // Cycles left in the push
  logic tog_q; // Noise on unused points
  wire logic [8:0] pts = {drv_out, 1'b0}; // Point zero reads low
  // Home input starts a push-motion return; clear or stop ends it
  always_ff @(posedge clock) begin
    tog_q <= rstn ? ~tog_q : 1'b0;
    if (!rstn || pts[stop_pt] || dev_clr) begin
      busy_q <= 1'b0;
    end else if (pts[start_pt] && !busy_q) begin
      busy_q <= 1'b1;
      cnt_q <= dly;
    end else if (busy_q) begin
      cnt_q <= cnt_q - 8'h1;
      busy_q <= cnt_q != 8'h0;
    end
  end
  // End high at rest, moving high in motion, other points toggle
  always_comb begin
    for (int k = 1; k <= 5; k++) begin
      drv_in[k] = (k == end_pt) ? !busy_q : (k == move_pt) ? busy_q : tog_q ^ k[0];
    end
  end
endmodule

// [test/hsd_top_tb_top.sv]
// Self-checking bench for the home-seek block
`timescale 1ns/1ps
`include "hsd_cfg.svh"
// ------------------------------------------------------------
// Bench top
// ------------------------------------------------------------
module hsd_top_tb_top;
  import hsd_pkg::*;
  localparam int PC = 4; // Short driver clear pulse
  logic clock, rstn, ce, wr, rd, home_detect, limit_found, panic_stop;
  logic diff_timing_input, single_timing_input, ext_index_input;
  logic timing_signal, seek_run, seek_dir_pos, own_dev_clear;
  logic alarm_deviation_clear_out, preset_out, system_alarm, irq;
  logic [7:0] addr;
  logic [31:0] wdata, rdata;
  logic [5:1] driver_in;
  logic [8:1] driver_out;
  logic [3:0] sp, ap; // Model start and stop points
  logic [2:0] ep, mp; // Model end and moving points
  logic [7:0] dly; // Model push length
  int error_cnt, n_tests, cyc;
  hsd_top #(.PULSE_CYC(PC)) i_hsd_top (.clock, .rstn, .ce, .addr, .wdata, .wr, .rd, .rdata,
    .diff_timing_input, .single_timing_input, .ext_index_input, .home_detect, .limit_found,
    .panic_stop, .driver_in, .driver_out, .timing_signal, .seek_run, .seek_dir_pos,
    .own_dev_clear, .alarm_deviation_clear_out, .preset_out, .system_alarm, .irq);
  hsd_drv_model i_hsd_drv_model (.clock, .rstn, .drv_out(driver_out),
    .dev_clr(alarm_deviation_clear_out), .start_pt(sp), .stop_pt(ap), .end_pt(ep),
    .move_pt(mp), .dly, .drv_in(driver_in));
  always #25 clock = ~clock;
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // Poll the state field until idle
  task automatic wait_idle(output logic [31:0] v);
    for (int i = 0; i < 80; i++) begin
      rd_reg(`HSD_OFS_STATUS, v);
      if (v[2:0] === 3'h0) break;
    end
  endtask
  function automatic logic exp_tim(logic [1:0] e, logic t, logic d, logic s, logic x);
    return t ? s : (e == 2'h1) ? d : (e == 2'h2) ? x : 1'b0;
  endfunction
  task automatic finish_test;
    $display("mismatches %0d of %0d checks", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Hang guard
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      finish_test();
    end
  end
  initial begin
    logic [31:0] v;
    logic [1:0] c;
    logic h;
    {clock, rstn, wr, rd, home_detect, limit_found, panic_stop, addr, wdata} = '0;
    {diff_timing_input, single_timing_input, ext_index_input, sp, ap, ep, mp} = '0;
    {ce, dly, cyc, error_cnt, n_tests} = '0;
    ce = 1'b1;
    void'($urandom(32'hae1e));
    repeat (8) @(posedge clock);
    rstn <= 1'b1;
    rd_reg(`HSD_OFS_CTRL, v); chk(v, 32'h0);
    rd_reg(`HSD_OFS_ASSIGN, v); chk(v, 32'h2);
    rd_reg(8'h1c, v); chk(v, 32'h0);
    wr_reg(`HSD_OFS_CTRL, 32'h1);
    wr_reg(`HSD_OFS_CTRL, 32'h3);
    ce <= 1'b0;
    wr_reg(`HSD_OFS_CTRL, 32'h2);
    ce <= 1'b1;
    rd_reg(`HSD_OFS_CTRL, v); chk(v[1:0], 2'h1);
    wr_reg(`HSD_OFS_ASSIGN, 32'h916);
    rd_reg(`HSD_OFS_ASSIGN, v); chk(v, 32'h12);
    // Timing source routing with random input levels
    for (int i = 0; i < 12; i++) begin
      wr_reg(`HSD_OFS_CTRL, {27'h0, 1'(i / 6), 2'(i % 3), 2'h0});
      repeat (2) begin
        @(posedge clock);
        {diff_timing_input, single_timing_input, ext_index_input} <= 3'($urandom);
        #1 chk(timing_signal, exp_tim(2'(i % 3), 1'(i / 6), diff_timing_input,
          single_timing_input, ext_index_input));
      end
    end
    // Own seek ended by home or limit under each clear select
    for (int i = 0; i < 6; i++) begin
      c = 2'(i % 3);
      h = i < 3;
      wr_reg(`HSD_OFS_CTRL, {30'h0, c});
      v = 32'h1 << ($urandom % 2);
      wr_reg(`HSD_OFS_CMD, v);
      #1 chk({seek_run, seek_dir_pos}, {1'b1, v[0]});
      @(posedge clock);
      home_detect <= h;
      limit_found <= !h;
      @(posedge clock);
      home_detect <= 1'b0;
      limit_found <= 1'b0;
      #1 chk(own_dev_clear, h && c != 2'h2);
      chk(alarm_deviation_clear_out, (h && c == 2'h1) || (!h && c != 2'h2));
      chk(preset_out, h);
      repeat (PC + 2) @(posedge clock);
    end
    for (int k = 0; k < 2; k++) begin
      wr_reg(`HSD_OFS_CTRL, k ? 32'h0 : 32'h2);
      wr_reg(`HSD_OFS_CMD, 32'h8);
      #1 chk(own_dev_clear, 1'b1);
      panic_stop <= 1'b1;
      @(posedge clock);
      panic_stop <= 1'b0;
      #1 chk({own_dev_clear, alarm_deviation_clear_out}, {2{k[0]}});
      repeat (PC + 2) @(posedge clock);
    end
    // Missing timing source, then interrupt enable, mask and clear
    wr_reg(`HSD_OFS_IRQ_CLR, 32'h1f);
    wr_reg(`HSD_OFS_IRQ_EN, 32'h4);
    wr_reg(`HSD_OFS_CTRL, 32'h100);
    wr_reg(`HSD_OFS_CMD, 32'h2);
    #1 chk({system_alarm, seek_run, irq}, 3'b101);
    wr_reg(`HSD_OFS_IRQ_EN, 32'h0);
    #1 chk(irq, 1'b0);
    wr_reg(`HSD_OFS_IRQ_EN, 32'h4);
    wr_reg(`HSD_OFS_IRQ_CLR, 32'h4);
    rd_reg(`HSD_OFS_IRQ_STAT, v); chk({v[2], irq}, 2'b00);
    // Sensor-less homing through the driver, both directions
    {sp, ap, ep, mp} <= {4'h5, 4'h3, 3'h2, 3'h1};
    wr_reg(`HSD_OFS_ASSIGN, 32'h5312);
    wr_reg(`HSD_OFS_CTRL, 32'hc00);
    for (int j = 0; j < 2; j++) begin
      dly <= 8'($urandom_range(1, 40));
      wr_reg(`HSD_OFS_IRQ_CLR, 32'h1f);
      wr_reg(`HSD_OFS_CMD, j ? 32'h1 : 32'h2);
      #1 chk({seek_run, driver_out}, 9'h010);
      wait_idle(v); chk(v[2:0], 3'h0);
      rd_reg(`HSD_OFS_IRQ_STAT, v); chk(v[1:0], 2'h1);
    end
    // Abort in mid-push
    dly <= 8'd200;
    wr_reg(`HSD_OFS_CMD, 32'h1);
    repeat (3) @(posedge clock);
    wr_reg(`HSD_OFS_CMD, 32'h4);
    #1 chk(driver_out, 8'h04);
    wait_idle(v); rd_reg(`HSD_OFS_IRQ_STAT, v); chk(v[1], 1'b1);
    // Unassigned points stay quiet
    wr_reg(`HSD_OFS_ASSIGN, 32'h0);
    wr_reg(`HSD_OFS_CMD, 32'h1);
    repeat (4) begin
      @(posedge clock);
      #1 chk(driver_out, 8'h0);
    end
    wr_reg(`HSD_OFS_CMD, 32'h4);
    #1 chk(driver_out, 8'h0);
    wait_idle(v); chk(v[2:0], 3'h0);
    finish_test();
  end
endmodule
